// file: hw/wrs_pkg.sv
// Constants shared by the watchdog restart synchroniser files
package wrs_pkg;

    // ************************************************************
    // Clock rates
    // ************************************************************
    localparam int unsigned SYS_CLK_HZ  = 40_000_000; // Block clock
    localparam int unsigned CORE_CLK_HZ = 12_000_000; // Core rate
    localparam int unsigned WDT_CLK_HZ  = 1_000_000;  // Watchdog rate
    // Block cycles per watchdog period, rounded down
    localparam int unsigned WDT_PERIOD_CYC = SYS_CLK_HZ / WDT_CLK_HZ;

    // ************************************************************
    // Disarm sequence on the core I/O space
    // ************************************************************
    localparam logic [5:0] WDT_CTRL_ADDR   = 6'h21; // Control location
    localparam logic [7:0] DISARM_FIRST    = 8'h18; // First write
    localparam logic [7:0] DISARM_SECOND   = 8'h10; // Second write

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic RST_ENABLED = 1'b1; // Watchdog armed after reset
    localparam logic RST_PENDING = 1'b0; // No restart waiting
    localparam logic RST_LEVEL   = 1'b0; // Synchroniser flops

    // Disarm sequence progress
    typedef enum logic [1:0] {
        WRS_IDLE,
        WRS_ARMED,
        WRS_OFF
    } wrs_state_e;

endpackage : wrs_pkg

// file: hw/wrs_sync3.sv
// Three-flop synchroniser with stable-level rise detect
`timescale 1ns/1ps
`default_nettype none
module wrs_sync3 (
    input  wire logic i_clock,
    input  wire logic i_nrst,
    input  wire logic i_async,  // Pin from a foreign clock
    output logic      o_level,  // Filtered stable level
    output logic      o_rise    // One-cycle pulse on a rising level
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic s1;    // First stage, read only by s2
        logic s2;    // Second stage
        logic s3;    // Third stage
        logic level; // Accepted level
        logic rise;  // Rise pulse
    } wrs_sync_s;

    wrs_sync_s st_q;
    wrs_sync_s st_d;

    // Next state: a change counts once stages two and three agree
    always_comb begin
        st_d      = st_q;
        st_d.s1   = i_async;
        st_d.s2   = st_q.s1;
        st_d.s3   = st_q.s2;
        st_d.rise = 1'b0;
        if (st_q.s2 == st_q.s3) begin
            st_d.level = st_q.s3;
            st_d.rise  = st_q.s3 & ~st_q.level;
        end
    end

    // Registers take constants only under reset
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= {5{wrs_pkg::RST_LEVEL}};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.level;
    assign o_rise  = st_q.rise;

endmodule : wrs_sync3
`default_nettype wire

// file: hw/wrs_restart_sync.sv
// Watchdog restart carrier and disarm sequence detector
`timescale 1ns/1ps
`default_nettype none
module wrs_restart_sync (
    input  wire logic       i_clock,        // 40 MHz block clock
    input  wire logic       i_nrst,         // Async reset, active low
    input  wire logic       i_core_en,      // One pulse per core cycle
    input  wire logic       i_watchdog_restart_instruction, // Restart
    input  wire logic       i_io_we,        // Core I/O write strobe
    input  wire logic [5:0] i_io_addr,      // Core I/O address
    input  wire logic [7:0] i_io_wdata,     // Core I/O write data
    input  wire logic       i_wdt_clock,    // 1 MHz watchdog clock pin
    output logic            o_wdt_restart,  // Restart on watchdog edge
    output logic            o_restart_pending, // Restart waiting
    output logic            o_wdt_enabled,  // Watchdog still armed
    output logic            o_wdt_tick      // Watchdog edge seen
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta_q; // First reset stage
    logic rst_sync_q; // Released reset used by the design

    // Release through two flops so all state leaves reset together
    // Assertion of reset is immediate; only its release is timed
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ************************************************************
    // Watchdog clock edge
    // ************************************************************
    logic wdt_level; // Filtered watchdog clock
    logic wdt_rise;  // Watchdog clock rising edge

    // Phase unknown, so the clock is sampled, never used as clock;
    // three to four cycles of delay against a 1 us period loses nothing
    wrs_sync3 u_wdt_sync (
        .i_clock (i_clock),
        .i_nrst  (rst_sync_q),
        .i_async (i_wdt_clock),
        .o_level (wdt_level),
        .o_rise  (wdt_rise)
    );

    // ************************************************************
    // State
    // ************************************************************
    // One packed state word, filled by one process, kept by another
    typedef struct packed {
        wrs_pkg::wrs_state_e state; // Disarm progress
        logic pending;              // Restart waiting for an edge
        logic restart;              // Restart pulse to the counter
        logic tick;                 // Edge marker
    } wrs_main_s;

    wrs_main_s st_q;
    wrs_main_s st_d;

    logic take;     // Restart accepted this cycle
    logic ctrl_wr;  // Write to the watchdog control location

    // Requests count only on a core cycle and only while armed
    assign take    = i_core_en & i_watchdog_restart_instruction
                   & (st_q.state != wrs_pkg::WRS_OFF);
    assign ctrl_wr = i_core_en & i_io_we
                   & (i_io_addr == wrs_pkg::WDT_CTRL_ADDR);

    // Next state for restart carrier and disarm detector
    always_comb begin
        st_d         = st_q;
        st_d.restart = 1'b0;
        st_d.tick    = wdt_rise;
        // Deliver the held request on the next watchdog edge
        if (wdt_rise && st_q.pending) begin
            st_d.restart = 1'b1;
            st_d.pending = 1'b0;
        end
        // A new request beats the clear in the same cycle, so a
        // request landing on a delivery edge waits for the next one
        if (take) begin
            st_d.pending = 1'b1;
        end
        // Ordered pair of writes; a repeated first byte holds, anything else restarts the sequence
        if (ctrl_wr) begin
            case (st_q.state)
                wrs_pkg::WRS_IDLE: begin
                    if (i_io_wdata == wrs_pkg::DISARM_FIRST) begin
                        st_d.state = wrs_pkg::WRS_ARMED;
                    end
                end
                wrs_pkg::WRS_ARMED: begin
                    if (i_io_wdata == wrs_pkg::DISARM_SECOND) begin
                        st_d.state = wrs_pkg::WRS_OFF;
                    end else if (i_io_wdata != wrs_pkg::DISARM_FIRST) begin
                        st_d.state = wrs_pkg::WRS_IDLE;
                    end
                end
                wrs_pkg::WRS_OFF: begin
                    // Stays off until reset
                    st_d.state = wrs_pkg::WRS_OFF;
                end
                default: begin
                    st_d.state = wrs_pkg::WRS_IDLE;
                end
            endcase
        end
        // Nothing to deliver once disarmed
        if (st_d.state == wrs_pkg::WRS_OFF) begin
            st_d.pending = 1'b0;
        end
    end

    // State register; the released reset copy clears the disarm
    // progress and any waiting restart together
    always_ff @(posedge i_clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            st_q.state   <= wrs_pkg::WRS_IDLE;
            st_q.pending <= wrs_pkg::RST_PENDING;
            st_q.restart <= 1'b0;
            st_q.tick    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs from flops; the raw one-cycle request would be missed
    // Enabled is decoded from state, so it cannot drift from it
    assign o_wdt_restart     = st_q.restart;
    assign o_restart_pending = st_q.pending;
    assign o_wdt_enabled     = (st_q.state != wrs_pkg::WRS_OFF);
    assign o_wdt_tick        = st_q.tick;

    // ************************************************************
    // Checks
    // ************************************************************
    // All checks sleep while the released reset is low, so the first
    // edges after release see only reset values through $past
    // Watchdog edges come about every 40 block cycles, which bounds
    // how long a taken restart may wait for delivery
    a_take_holds: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        (take && !(i_core_en && i_io_we)) |=> st_q.pending)
        else $error("Accepted restart not held");

    a_restart_cause: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        o_wdt_restart |-> ($past(st_q.pending) && $past(wdt_rise)))
        else $error("Restart without pending request and edge");

    a_pend_until_edge: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        (st_q.pending && !wdt_rise && o_wdt_enabled
         && !(i_core_en && i_io_we)) |=> st_q.pending)
        else $error("Pending restart dropped without edge");

    a_disarm_order: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        $fell(o_wdt_enabled) |-> ($past(st_q.state) == wrs_pkg::WRS_ARMED
            && $past(ctrl_wr)
            && $past(i_io_wdata) == wrs_pkg::DISARM_SECOND))
        else $error("Watchdog disabled without ordered writes");

    a_edge_is_rise: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        o_wdt_tick |-> (wdt_level && !$past(wdt_level, 2)))
        else $error("Tick without a filtered rising edge");

    c_restart_done: cover property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        take ##[1:60] o_wdt_restart);

    c_disarm: cover property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        $fell(o_wdt_enabled));

    c_take_on_edge: cover property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        take && wdt_rise && st_q.pending);

    // Edges are far apart, so a restart never lasts two cycles
    a_restart_single: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        o_wdt_restart |=> !o_wdt_restart)
        else $error("Restart pulse longer than one cycle");

    // Delivery only ever rides on a filtered watchdog edge
    a_restart_on_tick: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        o_wdt_restart |-> o_wdt_tick)
        else $error("Restart delivered off a watchdog edge");

    // A taken restart reaches the counter within one watchdog period
    // plus synchroniser delay, unless the watchdog is disarmed first
    a_take_delivered: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        (take && !(i_core_en && i_io_we))
        |-> ##[1:60] (o_wdt_restart || !o_wdt_enabled))
        else $error("Taken restart never delivered");

    // Disarmed means disarmed until the next reset
    a_off_stays: assert property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        !o_wdt_enabled |=> !o_wdt_enabled)
        else $error("Watchdog re-armed without reset");

    // Repeated first byte keeps the sequence armed
    c_first_again: cover property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        ctrl_wr && st_q.state == wrs_pkg::WRS_ARMED
        && i_io_wdata == wrs_pkg::DISARM_FIRST);

    // Restart attempted after disarm is dropped
    c_refused: cover property (@(posedge i_clock)
        disable iff (!rst_sync_q)
        i_core_en && i_watchdog_restart_instruction && !o_wdt_enabled);

endmodule : wrs_restart_sync
`default_nettype wire

// file: verif/wrs_core_model.sv
// Core-side partner: paced restart and I/O write issue
`timescale 1ns/1ps
`default_nettype none
module wrs_core_model (
    input  wire logic       i_clock,
    output logic            o_core_en,
    output logic            o_restart,
    output logic            o_io_we,
    output logic [5:0]      o_io_addr,
    output logic [7:0]      o_io_wdata
);
    // ************************************************************
    // Instruction pacing
    // ************************************************************
    logic [15:0] q[$];      // Queued {restart, we, addr, data}
    int          acc = 0;   // Adds 12 of 40 for a 12 MHz core
    logic [15:0] ins;       // Instruction of this core cycle
    logic        en;        // Core cycle strobe
    initial {o_core_en, o_restart, o_io_we, o_io_addr, o_io_wdata} = '0;
    // Each instruction lives one block cycle only, so it is short
    always @(posedge i_clock) begin
        acc = acc + 12;
        en  = (acc >= 40);
        ins = '0;
        if (en) begin
            acc = acc - 40;
            if (q.size() > 0) ins = q.pop_front();
        end
        o_core_en  <= en;
        o_restart  <= ins[15];
        o_io_we    <= ins[14];
        // Idle bus toggles so stale values never look valid
        o_io_addr  <= ins[14] ? ins[13:8] : ~o_io_addr;
        o_io_wdata <= ins[14] ? ins[7:0] : ~o_io_wdata;
    end
    // Queue one instruction
    task automatic push(input logic r, w, input logic [5:0] a,
                        input logic [7:0] d);
        q.push_back({r, w, a, d});
    endtask : push
endmodule : wrs_core_model
`default_nettype wire

// file: verif/watchdog_restart_sync_tb.sv
// Self-checking bench for the watchdog restart synchroniser
`timescale 1ns/1ps
`default_nettype none
module watchdog_restart_sync_tb;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        clock = 1'b0;  // 40 MHz block clock
    logic        wdt_clock = 1'b0; // 1 MHz, own phase
    logic        nrst  = 1'b0;  // Reset, active low
    wire logic   core_en, rst_req, io_we;
    wire logic [5:0] io_addr;
    wire logic [7:0] io_wdata;
    logic        restart, pending, enabled, tick;
    logic        m_en, m_pend, m_armed, t_take, t_dis; // Model state
    logic [1:0]  rel = 2'b00;     // Reset seen over the last two edges
    logic [5:0]  w_hist = '0;     // Watchdog pin as the block samples it
    logic        e_tick = 1'b0;   // Expected edge marker
    int          bad_count = 0, checks = 0, rises, ticks;
    always #12.5 clock = ~clock;
    // Unrelated phase to the block clock
    initial #137 forever #500 wdt_clock = ~wdt_clock;
    always @(posedge wdt_clock) if (nrst) rises++;
    // Pin samples count from the third edge after release; a rise
    // shows four edges later. The pin never moves on a clock edge.
    always @(posedge clock) begin
        if (rel[1] & rel[0] & nrst) w_hist = {w_hist[4:0], wdt_clock};
        else w_hist = '0;
        rel    = {rel[0], nrst};
        e_tick = w_hist[4] & ~w_hist[5];
    end
    wrs_core_model wrs_core_model_i (.i_clock(clock),
        .o_core_en(core_en), .o_restart(rst_req), .o_io_we(io_we),
        .o_io_addr(io_addr), .o_io_wdata(io_wdata));
    wrs_restart_sync wrs_restart_sync_i (.i_clock(clock), .i_nrst(nrst),
        .i_core_en(core_en), .i_watchdog_restart_instruction(rst_req),
        .i_io_we(io_we), .i_io_addr(io_addr), .i_io_wdata(io_wdata),
        .i_wdt_clock(wdt_clock), .o_wdt_restart(restart),
        .o_restart_pending(pending), .o_wdt_enabled(enabled),
        .o_wdt_tick(tick));
    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic check(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    // Model: effect of the last edge, then what the next edge takes
    always @(negedge clock) begin
        if (!nrst) begin
            {m_pend, m_armed, t_take, t_dis} = '0;
            m_en  = 1'b1;
            rises = 0;
            ticks = 0;
        end else begin
            check(tick, e_tick);
            check(restart, e_tick & m_pend);
            m_pend = t_take | (m_pend & ~e_tick);
            if (t_dis) {m_en, m_pend} = 2'b00;
            check(pending, m_pend);
            check(enabled, m_en);
            ticks  = ticks + int'(tick);
            t_take = core_en & rst_req & m_en;
            t_dis  = 1'b0;
            if (core_en & io_we & m_en
                & (io_addr == wrs_pkg::WDT_CTRL_ADDR)) begin
                t_dis   = m_armed & (io_wdata == wrs_pkg::DISARM_SECOND);
                m_armed = (io_wdata == wrs_pkg::DISARM_FIRST);
            end
        end
    end
    // Drain the core queue, then allow one and a half watchdog periods
    task automatic run_idle;
        int n;
        n = 0;
        while (wrs_core_model_i.q.size() > 0 && n < 4000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 4000) begin
            bad_count++;
            report_and_stop();
        end
        repeat (60) @(posedge clock);
    endtask : run_idle
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wrs_core_model_i.push(1'b0, 1'b1, a, d);
    endtask : wr
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        void'($urandom(49508));
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        // Lone one-cycle restart, then bursts of 14 and 26
        wrs_core_model_i.push(1'b1, 1'b0, 6'h00, 8'h00);
        run_idle();
        repeat (14) wrs_core_model_i.push(1'b1, 1'b0, 6'h00, 8'h00);
        run_idle();
        repeat (26) wrs_core_model_i.push(1'b1, 1'b0, 6'h00, 8'h00);
        run_idle();
        // Random restarts and stray writes at random spacing
        repeat (60) begin
            if ($urandom_range(1, 0) == 1)
                wrs_core_model_i.push(1'b1, 1'b0, 6'h00, 8'h00);
            else
                wr(6'($urandom), 8'($urandom));
            if ($urandom_range(3, 0) == 0) run_idle();
        end
        run_idle();
        // Lone second byte, broken pair, then a good pair
        wr(wrs_pkg::WDT_CTRL_ADDR, wrs_pkg::DISARM_SECOND);
        wr(wrs_pkg::WDT_CTRL_ADDR, wrs_pkg::DISARM_FIRST);
        wr(wrs_pkg::WDT_CTRL_ADDR, 8'h33);
        wr(wrs_pkg::WDT_CTRL_ADDR, wrs_pkg::DISARM_SECOND);
        wrs_core_model_i.push(1'b1, 1'b0, 6'h00, 8'h00);
        wr(wrs_pkg::WDT_CTRL_ADDR, wrs_pkg::DISARM_FIRST);
        wr(wrs_pkg::WDT_CTRL_ADDR, wrs_pkg::DISARM_FIRST);
        wr(6'h20, wrs_pkg::DISARM_SECOND);
        wr(wrs_pkg::WDT_CTRL_ADDR, wrs_pkg::DISARM_SECOND);
        wrs_core_model_i.push(1'b1, 1'b0, 6'h00, 8'h00);
        run_idle();
        // Reset in mid-run re-arms the watchdog
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        wrs_core_model_i.push(1'b1, 1'b0, 6'h00, 8'h00);
        run_idle();
        check(ticks >= rises - 1 && ticks <= rises + 1, 1'b1);
        report_and_stop();
    end
endmodule : watchdog_restart_sync_tb
`default_nettype wire
